// *** logic/eia_exec.sv ***
// Top of the extended-instruction ALU: work register, flags, write-back, skip
`timescale 1ns/1ps

module eia_exec
  import eia_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       op_valid,
  input  eia_op_t         op_code,
  input  wire logic [2:0] bit_sel,
  input  wire logic [7:0] mem_rdata,
  output logic            op_ready,
  output logic            dummy_cycle,
  output logic            mem_we,
  output logic [7:0]      mem_wdata,
  output logic [7:0]      work_register,
  output logic            signed_wrap_flag,
  output logic            null_result_flag,
  output logic            half_carry_flag,
  output logic            borrow_inverse_bit,
  output logic            signed_carry_flag,
  output logic            chained_null_flag
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] work;
    eia_flags_t flags;
    logic       mem_we;
    logic [7:0] mem_wdata;
  } eia_top_state_t;

  eia_top_state_t state_reg;
  eia_top_state_t state_next;
  logic           accept;
  logic           ready;

  eia_alu_if alu ();

  // ------------------------------------------------------------------
  // Operation unit and skip control
  // ------------------------------------------------------------------
  // Operands come straight from the sequencer and the current state
  assign alu.op       = op_code;
  assign alu.bit_sel  = bit_sel;
  assign alu.work     = state_reg.work;
  assign alu.mem      = mem_rdata;
  assign alu.flags_in = state_reg.flags;

  eia_op_unit u_op (
    .alu (alu)
  );

  eia_skip_ctl u_skip (
    .clock    (clock),
    .resetn   (resetn),
    .accept   (accept),
    .skip_req (alu.skip),
    .dummy    (dummy_cycle),
    .ready    (ready)
  );

  // Taken only outside the dummy slot
  assign accept   = op_valid & ready;
  assign op_ready = ready;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // Flags move only on an accepted operation, so a dummy slot keeps them
  always_comb begin
    state_next        = state_reg;
    state_next.mem_we = 1'b0;
    if (accept) begin
      state_next.flags = alu.flags_out;
      if (alu.wr_work) begin
        state_next.work = alu.result;
      end
      if (alu.wr_mem) begin
        state_next.mem_we    = 1'b1;
        state_next.mem_wdata = alu.result;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg.work      <= EIA_WORK_RST;
      state_reg.flags     <= EIA_FLAGS_RST;
      state_reg.mem_we    <= 1'b0;
      state_reg.mem_wdata <= EIA_WDATA_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Write data stays until the next write; the sequencer owns the address
  assign mem_we             = state_reg.mem_we;
  assign mem_wdata          = state_reg.mem_wdata;
  assign work_register      = state_reg.work;
  assign signed_wrap_flag   = state_reg.flags.signed_wrap_flag;
  assign null_result_flag   = state_reg.flags.null_result_flag;
  assign half_carry_flag    = state_reg.flags.half_carry_flag;
  assign borrow_inverse_bit = state_reg.flags.borrow_inverse_bit;
  assign signed_carry_flag  = state_reg.flags.signed_carry_flag;
  assign chained_null_flag  = state_reg.flags.chained_null_flag;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Copies of the operands of the last cycle, for the checks only
  logic       chk_took_q;
  eia_op_t    chk_op_q;
  logic [7:0] chk_mem_q;
  logic [7:0] chk_work_q;
  logic [2:0] chk_bit_q;
  eia_flags_t chk_flags_q;
  logic [5:0] chk_flag_diff;
  logic [8:0] chk_sbc_wide;
  logic [8:0] chk_sub_wide;
  logic       chk_skip_exp;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chk_took_q  <= 1'b0;
      chk_op_q    <= EIA_OP_NOP;
      chk_mem_q   <= 8'h00;
      chk_work_q  <= 8'h00;
      chk_bit_q   <= 3'h0;
      chk_flags_q <= EIA_FLAGS_RST;
    end else begin
      chk_took_q  <= accept;
      chk_op_q    <= op_code;
      chk_mem_q   <= mem_rdata;
      chk_work_q  <= state_reg.work;
      chk_bit_q   <= bit_sel;
      chk_flags_q <= state_reg.flags;
    end
  end

  // Independent reference arithmetic, written apart from the unit
  assign chk_flag_diff = state_reg.flags ^ chk_flags_q;
  assign chk_sbc_wide  = {1'b0, chk_work_q} - {1'b0, chk_mem_q}
                         - {8'h00, ~chk_flags_q.borrow_inverse_bit};
  assign chk_sub_wide  = {1'b0, chk_work_q} - {1'b0, chk_mem_q};

  // Skip condition computed from the raw operand of this cycle
  always_comb begin
    chk_skip_exp = 1'b0;
    case (op_code)
      EIA_OP_SDZ_M, EIA_OP_SDZ_W: chk_skip_exp = (mem_rdata == 8'h01);
      EIA_OP_SIZ_M, EIA_OP_SIZ_W: chk_skip_exp = (mem_rdata == 8'hFF);
      EIA_OP_SNZ_BIT:             chk_skip_exp = mem_rdata[bit_sel];
      EIA_OP_SNZ_BYTE:            chk_skip_exp = (mem_rdata != 8'h00);
      default:                    chk_skip_exp = 1'b0;
    endcase
  end

  default clocking cb_top @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_or_work_value: assert property (
    chk_took_q && chk_op_q == EIA_OP_OR_W |->
      work_register == (chk_work_q | chk_mem_q) && !mem_we
      && null_result_flag == ((chk_work_q | chk_mem_q) == 8'h00)
      && (chk_flag_diff & ~EIA_MASK_NULL) == 6'h00
  ) else $error("OR into work gave a wrong value or flag");

  chk_or_mem_write: assert property (
    chk_took_q && chk_op_q == EIA_OP_OR_M |->
      mem_we && mem_wdata == (chk_work_q | chk_mem_q)
      && work_register == chk_work_q
      && (chk_flag_diff & ~EIA_MASK_NULL) == 6'h00
  ) else $error("OR into memory gave a wrong write");

  chk_rotl_plain: assert property (
    chk_took_q && (chk_op_q == EIA_OP_RL_M || chk_op_q == EIA_OP_RL_W) |->
      (chk_op_q == EIA_OP_RL_M
        ? mem_we && mem_wdata == {chk_mem_q[6:0], chk_mem_q[7]}
        : !mem_we && work_register == {chk_mem_q[6:0], chk_mem_q[7]})
      && chk_flag_diff == 6'h00
  ) else $error("left rotate wrong");

  chk_rotl_carry: assert property (
    chk_took_q && (chk_op_q == EIA_OP_RLC_M || chk_op_q == EIA_OP_RLC_W) |->
      (chk_op_q == EIA_OP_RLC_M
        ? mem_we && mem_wdata == {chk_mem_q[6:0], chk_flags_q.borrow_inverse_bit}
        : !mem_we && work_register == {chk_mem_q[6:0], chk_flags_q.borrow_inverse_bit})
      && borrow_inverse_bit == chk_mem_q[7]
      && (chk_flag_diff & ~EIA_MASK_BORROW) == 6'h00
  ) else $error("left rotate through carry wrong");

  chk_rotr_plain: assert property (
    chk_took_q && (chk_op_q == EIA_OP_RR_M || chk_op_q == EIA_OP_RR_W) |->
      (chk_op_q == EIA_OP_RR_M
        ? mem_we && mem_wdata == {chk_mem_q[0], chk_mem_q[7:1]}
        : !mem_we && work_register == {chk_mem_q[0], chk_mem_q[7:1]})
      && chk_flag_diff == 6'h00
  ) else $error("right rotate wrong");

  chk_rotr_carry: assert property (
    chk_took_q && (chk_op_q == EIA_OP_RRC_M || chk_op_q == EIA_OP_RRC_W) |->
      (chk_op_q == EIA_OP_RRC_M
        ? mem_we && mem_wdata == {chk_flags_q.borrow_inverse_bit, chk_mem_q[7:1]}
        : !mem_we && work_register == {chk_flags_q.borrow_inverse_bit, chk_mem_q[7:1]})
      && borrow_inverse_bit == chk_mem_q[0]
      && (chk_flag_diff & ~EIA_MASK_BORROW) == 6'h00
  ) else $error("right rotate through carry wrong");

  chk_sub_borrow: assert property (
    chk_took_q && (chk_op_q == EIA_OP_SBC_W || chk_op_q == EIA_OP_SBC_M) |->
      (chk_op_q == EIA_OP_SBC_W
        ? !mem_we && work_register == chk_sbc_wide[7:0]
        : mem_we && mem_wdata == chk_sbc_wide[7:0] && work_register == chk_work_q)
      && borrow_inverse_bit == ~chk_sbc_wide[8]
      && null_result_flag == (chk_sbc_wide[7:0] == 8'h00)
      && chained_null_flag == ((chk_sbc_wide[7:0] == 8'h00) && chk_flags_q.chained_null_flag)
  ) else $error("borrow subtraction wrong");

  chk_sub_plain: assert property (
    chk_took_q && chk_op_q == EIA_OP_SUB_W |->
      work_register == chk_sub_wide[7:0] && !mem_we
      && borrow_inverse_bit == (chk_work_q >= chk_mem_q)
      && chained_null_flag == null_result_flag
      && signed_carry_flag == (signed_wrap_flag ^ work_register[7])
  ) else $error("plain subtraction wrong");

  chk_step_value: assert property (
    chk_took_q && (chk_op_q == EIA_OP_SDZ_M || chk_op_q == EIA_OP_SDZ_W
                  || chk_op_q == EIA_OP_SIZ_M || chk_op_q == EIA_OP_SIZ_W) |->
      ((chk_op_q == EIA_OP_SDZ_M && mem_we && mem_wdata == 8'(chk_mem_q - 8'h01))
       || (chk_op_q == EIA_OP_SDZ_W && !mem_we && work_register == 8'(chk_mem_q - 8'h01))
       || (chk_op_q == EIA_OP_SIZ_M && mem_we && mem_wdata == 8'(chk_mem_q + 8'h01))
       || (chk_op_q == EIA_OP_SIZ_W && !mem_we && work_register == 8'(chk_mem_q + 8'h01)))
      && chk_flag_diff == 6'h00
  ) else $error("step value or flags wrong");

  chk_set_value: assert property (
    chk_took_q && (chk_op_q == EIA_OP_SET_M || chk_op_q == EIA_OP_SETB_M) |->
      mem_we && chk_flag_diff == 6'h00
      && mem_wdata == (chk_op_q == EIA_OP_SET_M ? 8'hFF
                       : (chk_mem_q | 8'(8'h01 << chk_bit_q)))
  ) else $error("set byte or bit wrong");

  // Skip: one refused dummy slot, then ready again
  sequence s_skip_slot;
    ##1 (dummy_cycle && !op_ready) ##1 (!dummy_cycle && op_ready);
  endsequence

  chk_skip_taken: assert property (
    accept && chk_skip_exp |-> s_skip_slot
  ) else $error("skip did not insert exactly one dummy cycle");

  chk_skip_not_taken: assert property (
    accept && !chk_skip_exp |=> !dummy_cycle
  ) else $error("dummy cycle without a skip condition");

  chk_flags_hold: assert property (
    dummy_cycle |=> chk_flag_diff == 6'h00 && !mem_we
                    && work_register == chk_work_q
  ) else $error("state moved during a dummy cycle");

endmodule

// *** logic/eia_pkg.sv ***
// Opcodes, flag layout and reset values for the extended-instruction ALU
// ------------------------------------------------------------------------
// ------------------------------------------------------------------------
package eia_pkg;

  // Operations presented by the sequencer
  typedef enum logic [4:0] {
    EIA_OP_NOP, EIA_OP_OR_W, EIA_OP_OR_M, EIA_OP_RL_M, EIA_OP_RL_W,
    EIA_OP_RLC_M, EIA_OP_RLC_W, EIA_OP_RR_M, EIA_OP_RR_W, EIA_OP_RRC_M,
    EIA_OP_RRC_W, EIA_OP_SBC_W, EIA_OP_SBC_M, EIA_OP_SUB_W, EIA_OP_SDZ_M,
    EIA_OP_SDZ_W, EIA_OP_SIZ_M, EIA_OP_SIZ_W, EIA_OP_SET_M, EIA_OP_SETB_M,
    EIA_OP_SNZ_BIT, EIA_OP_SNZ_BYTE
  } eia_op_t;

  // Status flags, bit 5 down to bit 0
  typedef struct packed {
    logic signed_wrap_flag;
    logic null_result_flag;
    logic half_carry_flag;
    logic borrow_inverse_bit;
    logic signed_carry_flag;
    logic chained_null_flag;
  } eia_flags_t;

  localparam logic [5:0] EIA_MASK_NULL   = 6'h10;
  localparam logic [5:0] EIA_MASK_BORROW = 6'h04;
  localparam eia_flags_t EIA_FLAGS_RST   = 6'h00;
  localparam logic [7:0] EIA_WORK_RST    = 8'h00;
  localparam logic [7:0] EIA_WDATA_RST   = 8'h00;
  localparam logic [7:0] EIA_BYTE_ONE    = 8'h01;
  localparam logic [7:0] EIA_BYTE_ONES   = 8'hFF;

endpackage

// *** logic/eia_alu_if.sv ***
// Operand and result bundle between the top and the operation unit
`timescale 1ns/1ps

interface eia_alu_if;
  import eia_pkg::*;

  eia_op_t    op;
  logic [2:0] bit_sel;
  logic [7:0] work;
  logic [7:0] mem;
  eia_flags_t flags_in;
  logic [7:0] result;
  logic       wr_work;
  logic       wr_mem;
  logic       skip;
  eia_flags_t flags_out;

  modport unit (input op, bit_sel, work, mem, flags_in,
                output result, wr_work, wr_mem, skip, flags_out);
  modport ctl  (output op, bit_sel, work, mem, flags_in,
                input result, wr_work, wr_mem, skip, flags_out);
endinterface

// *** logic/eia_op_unit.sv ***
// Combinational operation unit: result, write targets, flags, skip request
`timescale 1ns/1ps

module eia_op_unit
  import eia_pkg::*;
(
  eia_alu_if.unit alu
);

  logic [7:0] a;
  logic [7:0] m;
  logic       c_in;
  logic       sbc;
  logic       borrow;
  logic [8:0] diff;
  logic [4:0] low;
  logic       ovf;
  logic [7:0] dec_v;
  logic [7:0] inc_v;

  // One shared subtractor; borrow only enters for the with-borrow forms
  assign a      = alu.work;
  assign m      = alu.mem;
  assign c_in   = alu.flags_in.borrow_inverse_bit;
  assign sbc    = (alu.op == EIA_OP_SBC_W) || (alu.op == EIA_OP_SBC_M);
  assign borrow = sbc & ~c_in;
  assign diff   = {1'b0, a} - {1'b0, m} - {8'h00, borrow};
  assign low    = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, borrow};
  assign ovf    = (a[7] ^ m[7]) & (a[7] ^ diff[7]);
  assign dec_v  = m - EIA_BYTE_ONE;
  assign inc_v  = m + EIA_BYTE_ONE;

  // Default keeps every flag; each case touches only its own flags
  always_comb begin
    alu.result    = m;
    alu.wr_work   = 1'b0;
    alu.wr_mem    = 1'b0;
    alu.skip      = 1'b0;
    alu.flags_out = alu.flags_in;
    case (alu.op)
      EIA_OP_OR_W, EIA_OP_OR_M: begin
        alu.result                     = a | m;
        alu.wr_work                    = (alu.op == EIA_OP_OR_W);
        alu.wr_mem                     = (alu.op == EIA_OP_OR_M);
        alu.flags_out.null_result_flag = ((a | m) == 8'h00);
      end
      EIA_OP_RL_M, EIA_OP_RL_W: begin
        alu.result  = {m[6:0], m[7]};
        alu.wr_work = (alu.op == EIA_OP_RL_W);
        alu.wr_mem  = (alu.op == EIA_OP_RL_M);
      end
      EIA_OP_RLC_M, EIA_OP_RLC_W: begin
        alu.result                       = {m[6:0], c_in};
        alu.wr_work                      = (alu.op == EIA_OP_RLC_W);
        alu.wr_mem                       = (alu.op == EIA_OP_RLC_M);
        alu.flags_out.borrow_inverse_bit = m[7];
      end
      EIA_OP_RR_M, EIA_OP_RR_W: begin
        alu.result  = {m[0], m[7:1]};
        alu.wr_work = (alu.op == EIA_OP_RR_W);
        alu.wr_mem  = (alu.op == EIA_OP_RR_M);
      end
      EIA_OP_RRC_M, EIA_OP_RRC_W: begin
        alu.result                       = {c_in, m[7:1]};
        alu.wr_work                      = (alu.op == EIA_OP_RRC_W);
        alu.wr_mem                       = (alu.op == EIA_OP_RRC_M);
        alu.flags_out.borrow_inverse_bit = m[0];
      end
      EIA_OP_SBC_W, EIA_OP_SBC_M, EIA_OP_SUB_W: begin
        alu.result                       = diff[7:0];
        alu.wr_work                      = (alu.op != EIA_OP_SBC_M);
        alu.wr_mem                       = (alu.op == EIA_OP_SBC_M);
        alu.flags_out.signed_wrap_flag   = ovf;
        alu.flags_out.null_result_flag   = (diff[7:0] == 8'h00);
        alu.flags_out.half_carry_flag    = ~low[4];
        alu.flags_out.borrow_inverse_bit = ~diff[8];
        alu.flags_out.signed_carry_flag  = ovf ^ diff[7];
        // Chained zero survives a with-borrow form only if the earlier byte was zero too; EIA_OP_SUB_W sets it from this byte alone
        alu.flags_out.chained_null_flag  = (diff[7:0] == 8'h00)
                                           & (~sbc | alu.flags_in.chained_null_flag);
      end
      EIA_OP_SDZ_M, EIA_OP_SDZ_W: begin
        alu.result  = dec_v;
        alu.wr_work = (alu.op == EIA_OP_SDZ_W);
        alu.wr_mem  = (alu.op == EIA_OP_SDZ_M);
        alu.skip    = (dec_v == 8'h00);
      end
      EIA_OP_SIZ_M, EIA_OP_SIZ_W: begin
        alu.result  = inc_v;
        alu.wr_work = (alu.op == EIA_OP_SIZ_W);
        alu.wr_mem  = (alu.op == EIA_OP_SIZ_M);
        alu.skip    = (inc_v == 8'h00);
      end
      EIA_OP_SET_M: begin
        alu.result = EIA_BYTE_ONES;
        alu.wr_mem = 1'b1;
      end
      EIA_OP_SETB_M: begin
        alu.result = m | (EIA_BYTE_ONE << alu.bit_sel);
        alu.wr_mem = 1'b1;
      end
      EIA_OP_SNZ_BIT:  alu.skip = m[alu.bit_sel];
      EIA_OP_SNZ_BYTE: alu.skip = (m != 8'h00);
      default: begin
        alu.skip = 1'b0;
      end
    endcase
  end

endmodule

// *** logic/eia_skip_ctl.sv ***
// Dummy-cycle insertion for the conditional-skip forms
`timescale 1ns/1ps

module eia_skip_ctl
  import eia_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic accept,
  input  wire logic skip_req,
  output logic      dummy,
  output logic      ready
);

  typedef struct packed {
    logic dummy;
  } eia_skip_state_t;

  eia_skip_state_t state_reg;
  eia_skip_state_t state_next;

  // One dummy slot while the skipped word is fetched and dropped
  always_comb begin
    state_next       = state_reg;
    state_next.dummy = accept & skip_req;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // No new operation during the dummy slot
  assign dummy = state_reg.dummy;
  assign ready = ~state_reg.dummy;

  default clocking cb_skip @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_dummy_single_slot: assert property (
    dummy |-> !ready ##1 !dummy
  ) else $error("dummy slot longer than one cycle");

endmodule

// *** verification/eia_seq_mem.sv ***
// Sequencer-side data-memory cell with write forwarding
`timescale 1ns/1ps

module eia_seq_mem (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_wdata,
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  output logic [7:0]      mem_rdata
);
  logic [7:0] cell_reg;

  // ----------------------------------------------------------------
  // Cell storage
  // ----------------------------------------------------------------
  // Preload from the bench wins over a late write-back
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cell_reg <= 8'h00;
    end else if (load) begin
      cell_reg <= load_data;
    end else if (mem_we) begin
      cell_reg <= mem_wdata;
    end
  end

  // Forward a pending write; the core has no bypass of its own
  assign mem_rdata = mem_we ? mem_wdata : cell_reg;
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the extended-instruction ALU
`timescale 1ns/1ps

module tb_top;
  import eia_pkg::*;

  typedef struct {
    eia_op_t op; logic [2:0] bs; logic c; logic [7:0] w, m;
    logic we; logic [7:0] xm, xw; logic [5:0] mk, fv; logic sk;
  } eia_row_t;

  logic       clock, resetn, op_valid, load, op_ready, dummy_cycle, mem_we;
  eia_op_t    op_code;
  logic [2:0] bit_sel;
  logic [7:0] mem_rdata, mem_wdata, work_register, load_data;
  logic       signed_wrap_flag, null_result_flag, half_carry_flag;
  logic       borrow_inverse_bit, signed_carry_flag, chained_null_flag;
  logic [5:0] flags_seen, ef;
  int         n_fail, n_compared;

  // ----------------------------------------------------------------
  // Rows: op, bit, carry, work, mem, write, mem out, work out, mask, flags, skip
  // ----------------------------------------------------------------
  eia_row_t rows [28] = '{
'{EIA_OP_OR_W,3'h0,1'h0,8'h50,8'h0A,1'h0,8'h00,8'h5A,6'h10,6'h00,1'h0},
'{EIA_OP_OR_W,3'h0,1'h1,8'h00,8'h00,1'h0,8'h00,8'h00,6'h10,6'h10,1'h0},
'{EIA_OP_OR_M,3'h0,1'h0,8'h81,8'h18,1'h1,8'h99,8'h81,6'h10,6'h00,1'h0},
'{EIA_OP_RL_M,3'h0,1'h0,8'h33,8'h81,1'h1,8'h03,8'h33,6'h00,6'h00,1'h0},
'{EIA_OP_RL_W,3'h0,1'h0,8'h33,8'h81,1'h0,8'h00,8'h03,6'h00,6'h00,1'h0},
'{EIA_OP_RLC_M,3'h0,1'h0,8'h33,8'h80,1'h1,8'h00,8'h33,6'h04,6'h04,1'h0},
'{EIA_OP_RLC_W,3'h0,1'h1,8'h33,8'h01,1'h0,8'h00,8'h03,6'h04,6'h00,1'h0},
'{EIA_OP_RR_M,3'h0,1'h0,8'h33,8'h01,1'h1,8'h80,8'h33,6'h00,6'h00,1'h0},
'{EIA_OP_RR_W,3'h0,1'h0,8'h33,8'h02,1'h0,8'h00,8'h01,6'h00,6'h00,1'h0},
'{EIA_OP_RRC_M,3'h0,1'h0,8'h33,8'h01,1'h1,8'h00,8'h33,6'h04,6'h04,1'h0},
'{EIA_OP_RRC_W,3'h0,1'h1,8'h33,8'h80,1'h0,8'h00,8'hC0,6'h04,6'h00,1'h0},
'{EIA_OP_SUB_W,3'h0,1'h0,8'h05,8'h03,1'h0,8'h00,8'h02,6'h3F,6'h0C,1'h0},
'{EIA_OP_SUB_W,3'h0,1'h0,8'h80,8'h01,1'h0,8'h00,8'h7F,6'h3F,6'h26,1'h0},
'{EIA_OP_SBC_W,3'h0,1'h0,8'h03,8'h03,1'h0,8'h00,8'hFF,6'h3F,6'h02,1'h0},
'{EIA_OP_SBC_M,3'h0,1'h1,8'h10,8'h10,1'h1,8'h00,8'h10,6'h3F,6'h1C,1'h0},
'{EIA_OP_SUB_W,3'h0,1'h1,8'h07,8'h07,1'h0,8'h00,8'h00,6'h3F,6'h1D,1'h0},
'{EIA_OP_SBC_W,3'h0,1'h1,8'h20,8'h20,1'h0,8'h00,8'h00,6'h3F,6'h1D,1'h0},
'{EIA_OP_SDZ_M,3'h0,1'h0,8'h44,8'h01,1'h1,8'h00,8'h44,6'h00,6'h00,1'h1},
'{EIA_OP_SDZ_M,3'h0,1'h0,8'h44,8'h00,1'h1,8'hFF,8'h44,6'h00,6'h00,1'h0},
'{EIA_OP_SDZ_W,3'h0,1'h0,8'h44,8'h01,1'h0,8'h00,8'h00,6'h00,6'h00,1'h1},
'{EIA_OP_SIZ_M,3'h0,1'h0,8'h44,8'hFF,1'h1,8'h00,8'h44,6'h00,6'h00,1'h1},
'{EIA_OP_SIZ_W,3'h0,1'h0,8'h44,8'h7F,1'h0,8'h00,8'h80,6'h00,6'h00,1'h0},
'{EIA_OP_SET_M,3'h0,1'h0,8'h44,8'h12,1'h1,8'hFF,8'h44,6'h00,6'h00,1'h0},
'{EIA_OP_SETB_M,3'h7,1'h0,8'h44,8'h00,1'h1,8'h80,8'h44,6'h00,6'h00,1'h0},
'{EIA_OP_SNZ_BIT,3'h3,1'h0,8'h44,8'h08,1'h0,8'h00,8'h44,6'h00,6'h00,1'h1},
'{EIA_OP_SNZ_BIT,3'h2,1'h0,8'h44,8'hFB,1'h0,8'h00,8'h44,6'h00,6'h00,1'h0},
'{EIA_OP_SNZ_BYTE,3'h0,1'h0,8'h44,8'h01,1'h0,8'h00,8'h44,6'h00,6'h00,1'h1},
'{EIA_OP_SNZ_BYTE,3'h0,1'h0,8'h44,8'h00,1'h0,8'h00,8'h44,6'h00,6'h00,1'h0}};

  assign flags_seen = {signed_wrap_flag, null_result_flag, half_carry_flag,
                       borrow_inverse_bit, signed_carry_flag, chained_null_flag};

  eia_exec u_dut (.clock(clock), .resetn(resetn), .op_valid(op_valid),
    .op_code(op_code), .bit_sel(bit_sel), .mem_rdata(mem_rdata),
    .op_ready(op_ready), .dummy_cycle(dummy_cycle), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .work_register(work_register),
    .signed_wrap_flag(signed_wrap_flag), .null_result_flag(null_result_flag),
    .half_carry_flag(half_carry_flag), .borrow_inverse_bit(borrow_inverse_bit),
    .signed_carry_flag(signed_carry_flag), .chained_null_flag(chained_null_flag));

  eia_seq_mem u_mem (.clock(clock), .resetn(resetn), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .load(load), .load_data(load_data), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Narrow results reuse the byte compare; unknowns still mismatch
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic cmp_flags(input logic [5:0] got, input logic [5:0] exp);
    cmp_byte({2'h0, got}, {2'h0, exp});
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Preload the cell, offer one operation, return in the answer cycle
  task automatic run(input eia_op_t op, input logic [2:0] bs, input logic [7:0] m);
    int n;
    n = 0;
    @(posedge clock);
    load <= 1'h1;
    load_data <= m;
    @(posedge clock);
    load <= 1'h0;
    op_valid <= 1'h1;
    op_code <= op;
    bit_sel <= bs;
    do begin
      @(negedge clock);
      n++;
    end while (op_ready !== 1'h1 && n < 8);
    if (op_ready !== 1'h1) begin
      n_fail++;
      tally_and_finish();
    end
    @(posedge clock);
    op_valid <= 1'h0;
    op_code <= EIA_OP_NOP;
    @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    resetn = 1'h0;
    op_valid = 1'h0;
    op_code = EIA_OP_NOP;
    bit_sel = 3'h0;
    load = 1'h0;
    load_data = 8'h00;
    ef = 6'h00;
    repeat (16) @(posedge clock);
    resetn <= 1'h1;
    @(negedge clock);
    cmp_flags(flags_seen, 6'h00);
    cmp_bit(op_ready, 1'h1);
    // Carry and work are set up through the design itself before each row
    foreach (rows[i]) begin
      ef[2] = rows[i].c;
      run(EIA_OP_RRC_M, 3'h0, {7'h00, rows[i].c});
      run(EIA_OP_SIZ_W, 3'h0, rows[i].w - 8'h01);
      run(rows[i].op, rows[i].bs, rows[i].m);
      ef = (ef & ~rows[i].mk) | (rows[i].fv & rows[i].mk);
      cmp_byte(work_register, rows[i].xw);
      cmp_bit(mem_we, rows[i].we);
      if (rows[i].we) cmp_byte(mem_wdata, rows[i].xm);
      cmp_flags(flags_seen, ef);
      cmp_bit(dummy_cycle, rows[i].sk);
      cmp_bit(op_ready, !rows[i].sk);
      if (rows[i].sk) begin
        @(negedge clock);
        cmp_flags(flags_seen, ef);
      end
      $display("row %0d done", i);
    end
    // Operation held through the dummy cycle is taken one cycle late
    @(posedge clock);
    load <= 1'h1;
    load_data <= 8'h01;
    @(posedge clock);
    load <= 1'h0;
    op_valid <= 1'h1;
    op_code <= EIA_OP_SDZ_M;
    @(posedge clock);
    op_code <= EIA_OP_SET_M;
    @(negedge clock);
    cmp_bit(dummy_cycle, 1'h1);
    cmp_bit(op_ready, 1'h0);
    @(negedge clock);
    cmp_bit(mem_we, 1'h0);
    @(posedge clock);
    op_valid <= 1'h0;
    @(negedge clock);
    cmp_byte(mem_wdata, 8'hFF);
    cmp_bit(mem_we, 1'h1);
    $display("held operation test done");
    // Mid-run reset acts without a clock edge
    @(posedge clock);
    resetn <= 1'h0;
    #1;
    cmp_byte(work_register, 8'h00);
    cmp_flags(flags_seen, 6'h00);
    cmp_bit(op_ready, 1'h1);
    cmp_bit(dummy_cycle, 1'h0);
    cmp_bit(mem_we, 1'h0);
    @(posedge clock);
    resetn <= 1'h1;
    // First operation straight after release is taken normally
    run(EIA_OP_SIZ_W, 3'h0, 8'h41);
    cmp_byte(work_register, 8'h42);
    cmp_flags(flags_seen, 6'h00);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
